/* File: src/fps_ctrl.sv */
// The plain strobed port and the register addresses are this design's own decisions.
`timescale 1ns/100ps
module fps_ctrl #(
  parameter int ADDR_W = fps_pkg::ADDR_W,
  parameter int BUF_DEPTH = fps_pkg::BUF_DEPTH,
  parameter int BUF_AW = fps_pkg::BUF_AW
) (
  input wire logic sys_clk_in,
  input wire logic rstn_in,
  input wire logic [7:0] reg_addr_in,
  input wire logic [31:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [31:0] reg_rdata_out,
  output logic irq_out,
  output fps_pkg::fps_bus_t flash_bus_out,
  input wire logic [fps_pkg::DQ_W-1:0] flash_dq_in,
  input wire logic flash_sts_in
);
  localparam int DQ_W = fps_pkg::DQ_W;
  localparam int STEP_W = fps_pkg::STEP_W;
  localparam logic [STEP_W-1:0] FIRST_DATA_STEP = STEP_W'(3);
  // Strobe rises at this count, so it stays low T_WP_CYC whole cycles
  localparam logic [3:0] WP_LAST = 4'(fps_pkg::T_WP_CYC);
  localparam logic [3:0] WPH_LAST = 4'(fps_pkg::T_WPH_CYC - 1);

  typedef enum {ST_IDLE, ST_FETCH, ST_LOAD, ST_WLOW, ST_WHIGH} fps_state_t;

  // Pads a command byte onto the data bus
  function automatic logic [DQ_W-1:0] cmd_word(input logic [7:0] code);
    cmd_word = {{(DQ_W-8){1'b0}}, code};
  endfunction

  fps_state_t state_reg, state_next;
  fps_pkg::fps_bus_t bus_reg, bus_next;
  logic [2:0] op_reg, op_next;
  logic [STEP_W-1:0] step_reg, step_next;
  logic [STEP_W-1:0] last_reg, last_next;
  logic [3:0] tmr_reg, tmr_next;
  logic [1:0] sts_mode_reg, sts_mode_next;
  logic done_pulse;

  logic [2:0] ctrl_op_reg, ctrl_op_next;
  logic [ADDR_W-1:0] addr_reg, addr_next;
  logic [DQ_W-1:0] data_reg, data_next;
  logic [BUF_AW-1:0] count_reg, count_next;
  logic [BUF_AW-1:0] buf_ptr_reg, buf_ptr_next;
  logic [fps_pkg::IRQ_W-1:0] irq_stat_reg, irq_stat_next;
  logic [fps_pkg::IRQ_W-1:0] irq_mask_reg, irq_mask_next;
  logic [31:0] rdata_next;
  logic irq_next;
  logic start_req;
  logic buf_wr;
  logic [BUF_AW-1:0] buf_rd_addr;
  logic [DQ_W-1:0] buf_rd_data;

  logic sts_meta_reg, sts_sync_reg, sts_prev_reg;
  logic [DQ_W-1:0] dq_meta_reg, dq_sync_reg;
  logic sts_event;

  fps_buf_mem #(
    .WIDTH(DQ_W),
    .DEPTH(BUF_DEPTH),
    .AW(BUF_AW)
  ) u_buf (
    .sys_clk_in(sys_clk_in),
    .rstn_in(rstn_in),
    .wr_en_in(buf_wr),
    .wr_addr_in(buf_ptr_reg),
    .wr_data_in(reg_wdata_in[DQ_W-1:0]),
    .rd_addr_in(buf_rd_addr),
    .rd_data_out(buf_rd_data)
  );

  // Buffer word for the coming data step; read one cycle ahead
  assign buf_rd_addr = BUF_AW'(step_reg - FIRST_DATA_STEP);

  // Sequencer: one flash write cycle per step
  always_comb begin
    state_next = state_reg;
    bus_next = bus_reg;
    op_next = op_reg;
    step_next = step_reg;
    last_next = last_reg;
    tmr_next = tmr_reg;
    sts_mode_next = sts_mode_reg;
    done_pulse = 1'b0;
    case (state_reg)
      ST_IDLE: begin
        bus_next = fps_pkg::BUS_IDLE;
        if (start_req) begin
          // Op arrives with the start bit, so take it from the same write
          op_next = ctrl_op_next;
          step_next = '0;
          case (ctrl_op_next)
            fps_pkg::OP_CLEAR_STATUS: last_next = '0;
            // Code, sub-op, count, N words, confirm
            fps_pkg::OP_EXT_FUNC:
              last_next = STEP_W'(count_reg) + STEP_W'(4);
            default: last_next = STEP_W'(1);
          endcase
          state_next = ST_FETCH;
        end
      end
      ST_FETCH: begin
        state_next = ST_LOAD;
      end
      ST_LOAD: begin
        // Address and data settle with chip enable before the strobe
        bus_next.addr = addr_reg;
        bus_next.dq_oe = 1'b1;
        bus_next.ce_n = 1'b0;
        bus_next.we_n = 1'b1;
        bus_next.oe_n = 1'b1;
        if (step_reg == '0) begin
          case (op_reg)
            fps_pkg::OP_PROT_PROG:
              bus_next.dq = cmd_word(fps_pkg::CMD_PROT_SETUP);
            fps_pkg::OP_EXT_FUNC:
              bus_next.dq = cmd_word(fps_pkg::CMD_EXT_FUNC);
            fps_pkg::OP_STS_CONFIG:
              bus_next.dq = cmd_word(fps_pkg::CMD_STS_SETUP);
            fps_pkg::OP_CLEAR_STATUS:
              bus_next.dq = cmd_word(fps_pkg::CMD_CLEAR_STATUS);
            default:
              bus_next.dq = cmd_word(fps_pkg::CMD_LOCK_SETUP);
          endcase
        end else if (step_reg == STEP_W'(1)) begin
          case (op_reg)
            fps_pkg::OP_LOCK:
              bus_next.dq = cmd_word(fps_pkg::CMD_LOCK);
            fps_pkg::OP_UNLOCK_ALL:
              bus_next.dq = cmd_word(fps_pkg::CMD_UNLOCK);
            // Any other code here is a sequence error at the device
            fps_pkg::OP_LOCK_RAW:
              bus_next.dq = cmd_word(data_reg[7:0]);
            fps_pkg::OP_STS_CONFIG:
              bus_next.dq = {{(DQ_W-2){1'b0}}, data_reg[1:0]};
            default: bus_next.dq = data_reg;
          endcase
        end else if (step_reg == STEP_W'(2)) begin
          bus_next.dq = {{(DQ_W-BUF_AW){1'b0}}, count_reg};
        end else if (step_reg == last_reg) begin
          bus_next.dq = cmd_word(fps_pkg::CMD_CONFIRM);
        end else begin
          bus_next.addr = addr_reg +
            ADDR_W'(step_reg - FIRST_DATA_STEP);
          bus_next.dq = buf_rd_data;
        end
        tmr_next = '0;
        state_next = ST_WLOW;
      end
      ST_WLOW: begin
        bus_next.we_n = 1'b0;
        tmr_next = tmr_reg + 4'h1;
        if (tmr_reg == WP_LAST) begin
          bus_next.we_n = 1'b1;
          tmr_next = '0;
          state_next = ST_WHIGH;
        end
      end
      ST_WHIGH: begin
        // Data held past the strobe's rising edge for hold time
        tmr_next = tmr_reg + 4'h1;
        if (tmr_reg == WPH_LAST) begin
          bus_next = fps_pkg::BUS_IDLE;
          bus_next.addr = bus_reg.addr;
          if (step_reg == last_reg) begin
            done_pulse = 1'b1;
            state_next = ST_IDLE;
            if (op_reg == fps_pkg::OP_STS_CONFIG) begin
              sts_mode_next = data_reg[1:0];
            end
          end else begin
            step_next = step_reg + STEP_W'(1);
            state_next = ST_FETCH;
          end
        end
      end
      default: begin
        state_next = ST_IDLE;
        bus_next = fps_pkg::BUS_IDLE;
      end
    endcase
  end

  always_ff @(posedge sys_clk_in) begin
    if (!rstn_in) begin
      state_reg <= ST_IDLE;
      bus_reg <= fps_pkg::BUS_IDLE;
      op_reg <= fps_pkg::OP_LOCK;
      step_reg <= '0;
      last_reg <= '0;
      tmr_reg <= '0;
      sts_mode_reg <= fps_pkg::STS_LEVEL;
    end else begin
      state_reg <= state_next;
      bus_reg <= bus_next;
      op_reg <= op_next;
      step_reg <= step_next;
      last_reg <= last_next;
      tmr_reg <= tmr_next;
      sts_mode_reg <= sts_mode_next;
    end
  end

  // Completion pin: level mode reports ready rising, pulse modes the
  // falling edge that starts each pulse, so one event per pulse
  always_comb begin
    if (sts_mode_reg == fps_pkg::STS_LEVEL) begin
      sts_event = sts_sync_reg && !sts_prev_reg;
    end else begin
      sts_event = !sts_sync_reg && sts_prev_reg;
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (!rstn_in) begin
      sts_meta_reg <= 1'b1;
      sts_sync_reg <= 1'b1;
      sts_prev_reg <= 1'b1;
      dq_meta_reg <= '0;
      dq_sync_reg <= '0;
    end else begin
      sts_meta_reg <= flash_sts_in;
      sts_sync_reg <= sts_meta_reg;
      sts_prev_reg <= sts_sync_reg;
      dq_meta_reg <= flash_dq_in;
      dq_sync_reg <= dq_meta_reg;
    end
  end

  // Register file
  always_comb begin
    ctrl_op_next = ctrl_op_reg;
    addr_next = addr_reg;
    data_next = data_reg;
    count_next = count_reg;
    buf_ptr_next = buf_ptr_reg;
    irq_mask_next = irq_mask_reg;
    irq_stat_next = irq_stat_reg;
    start_req = 1'b0;
    buf_wr = 1'b0;
    rdata_next = '0;
    if (reg_wr_in) begin
      case (reg_addr_in)
        fps_pkg::REG_CTRL: begin
          ctrl_op_next = reg_wdata_in[2:0];
          // A start while busy is dropped; software polls busy first
          start_req = reg_wdata_in[fps_pkg::CTRL_START_BIT] &&
                      (state_reg == ST_IDLE);
        end
        fps_pkg::REG_ADDR: addr_next = reg_wdata_in[ADDR_W-1:0];
        fps_pkg::REG_DATA: data_next = reg_wdata_in[DQ_W-1:0];
        fps_pkg::REG_COUNT: count_next = reg_wdata_in[BUF_AW-1:0];
        fps_pkg::REG_IRQ_MASK:
          irq_mask_next = reg_wdata_in[fps_pkg::IRQ_W-1:0];
        fps_pkg::REG_IRQ_STAT:
          irq_stat_next = irq_stat_reg &
                          ~reg_wdata_in[fps_pkg::IRQ_W-1:0];
        fps_pkg::REG_BUF_PTR: buf_ptr_next = reg_wdata_in[BUF_AW-1:0];
        fps_pkg::REG_BUF_DATA: begin
          buf_wr = 1'b1;
          buf_ptr_next = buf_ptr_reg + BUF_AW'(1);
        end
        default: begin
        end
      endcase
    end
    // New events win over a clear in the same cycle
    if (done_pulse) begin
      irq_stat_next[fps_pkg::IRQ_DONE_BIT] = 1'b1;
    end
    if (sts_event) begin
      irq_stat_next[fps_pkg::IRQ_STS_BIT] = 1'b1;
    end
    irq_next = |(irq_stat_next & irq_mask_next);
    if (reg_rd_in) begin
      case (reg_addr_in)
        fps_pkg::REG_CTRL: rdata_next[2:0] = ctrl_op_reg;
        fps_pkg::REG_ADDR: rdata_next[ADDR_W-1:0] = addr_reg;
        fps_pkg::REG_DATA: rdata_next[DQ_W-1:0] = data_reg;
        fps_pkg::REG_COUNT: rdata_next[BUF_AW-1:0] = count_reg;
        fps_pkg::REG_STATUS: begin
          rdata_next[fps_pkg::ST_BUSY_BIT] = (state_reg != ST_IDLE);
          rdata_next[fps_pkg::ST_MODE_LSB +: 2] = sts_mode_reg;
          rdata_next[fps_pkg::ST_PIN_BIT] = sts_sync_reg;
          rdata_next[fps_pkg::ST_STEP_LSB +: STEP_W] = step_reg;
        end
        fps_pkg::REG_IRQ_STAT:
          rdata_next[fps_pkg::IRQ_W-1:0] = irq_stat_reg;
        fps_pkg::REG_IRQ_MASK:
          rdata_next[fps_pkg::IRQ_W-1:0] = irq_mask_reg;
        fps_pkg::REG_BUF_PTR: rdata_next[BUF_AW-1:0] = buf_ptr_reg;
        fps_pkg::REG_BUF_DATA:
          rdata_next[DQ_W-1:0] = dq_sync_reg;
        default: rdata_next = '0;
      endcase
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (!rstn_in) begin
      ctrl_op_reg <= fps_pkg::OP_LOCK;
      addr_reg <= '0;
      data_reg <= '0;
      count_reg <= '0;
      buf_ptr_reg <= '0;
      irq_stat_reg <= '0;
      irq_mask_reg <= '0;
      reg_rdata_out <= '0;
      irq_out <= 1'b0;
    end else begin
      ctrl_op_reg <= ctrl_op_next;
      addr_reg <= addr_next;
      data_reg <= data_next;
      count_reg <= count_next;
      buf_ptr_reg <= buf_ptr_next;
      irq_stat_reg <= irq_stat_next;
      irq_mask_reg <= irq_mask_next;
      reg_rdata_out <= rdata_next;
      irq_out <= irq_next;
    end
  end

  assign flash_bus_out = bus_reg;
endmodule // fps_ctrl

/* File: src/fps_pkg.sv */
// How it works
// - Lock setup code opens two-cycle lock change
// - Protection setup precedes register program cycle
// - Extended command: code, sub-op, count minus one
// - Each later write loads one buffer word
// - Pin config setup then configuration code cycle
// - Only the clear-status code clears error flags
// - Confirm cycle ends the extended command
package fps_pkg;
  localparam int ADDR_W = 24;
  localparam int DQ_W = 16;
  localparam int BUF_DEPTH = 512;
  localparam int BUF_AW = 9;
  localparam int STEP_W = 10;

  // Device command codes
  localparam logic [7:0] CMD_LOCK_SETUP = 8'h60;
  localparam logic [7:0] CMD_LOCK = 8'h01;
  localparam logic [7:0] CMD_UNLOCK = 8'hD0;
  localparam logic [7:0] CMD_PROT_SETUP = 8'hC0;
  localparam logic [7:0] CMD_EXT_FUNC = 8'hEB;
  localparam logic [7:0] CMD_CONFIRM = 8'hD0;
  localparam logic [7:0] CMD_STS_SETUP = 8'hB8;
  localparam logic [7:0] CMD_CLEAR_STATUS = 8'h50;

  // Completion pin configuration codes
  localparam logic [1:0] STS_LEVEL = 2'h0;
  localparam logic [1:0] STS_PULSE_ERASE = 2'h1;
  localparam logic [1:0] STS_PULSE_PROG = 2'h2;
  localparam logic [1:0] STS_PULSE_BOTH = 2'h3;

  // Operations that software starts
  localparam logic [2:0] OP_LOCK = 3'h0;
  localparam logic [2:0] OP_UNLOCK_ALL = 3'h1;
  localparam logic [2:0] OP_LOCK_RAW = 3'h2;
  localparam logic [2:0] OP_PROT_PROG = 3'h3;
  localparam logic [2:0] OP_EXT_FUNC = 3'h4;
  localparam logic [2:0] OP_STS_CONFIG = 3'h5;
  localparam logic [2:0] OP_CLEAR_STATUS = 3'h6;

  // Controller register offsets
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_ADDR = 8'h04;
  localparam logic [7:0] REG_DATA = 8'h08;
  localparam logic [7:0] REG_COUNT = 8'h0C;
  localparam logic [7:0] REG_STATUS = 8'h10;
  localparam logic [7:0] REG_IRQ_STAT = 8'h14;
  localparam logic [7:0] REG_IRQ_MASK = 8'h18;
  localparam logic [7:0] REG_BUF_PTR = 8'h1C;
  localparam logic [7:0] REG_BUF_DATA = 8'h20;

  // Field positions
  localparam int CTRL_START_BIT = 8;
  localparam int IRQ_DONE_BIT = 0;
  localparam int IRQ_STS_BIT = 1;
  localparam int IRQ_W = 2;
  localparam int ST_BUSY_BIT = 0;
  localparam int ST_MODE_LSB = 1;
  localparam int ST_PIN_BIT = 3;
  localparam int ST_STEP_LSB = 16;

  // Write cycle timing
  localparam int CLK_MHZ = 40;
  localparam int T_WP_NS = 60;
  localparam int T_WPH_NS = 30;
  localparam int T_WP_CYC = (T_WP_NS * CLK_MHZ + 999) / 1000;
  localparam int T_WPH_CYC = (T_WPH_NS * CLK_MHZ + 999) / 1000;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DQ_W-1:0] dq;
    logic dq_oe;
    logic ce_n;
    logic we_n;
    logic oe_n;
  } fps_bus_t;

  localparam fps_bus_t BUS_IDLE = '{addr: '0, dq: '0, dq_oe: 1'b0,
                                   ce_n: 1'b1, we_n: 1'b1, oe_n: 1'b1};
endpackage

/* File: src/fps_buf_mem.sv */
`timescale 1ns/100ps
module fps_buf_mem #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 512,
  parameter int AW = 9
) (
  input wire logic sys_clk_in,
  input wire logic rstn_in,
  input wire logic wr_en_in,
  input wire logic [AW-1:0] wr_addr_in,
  input wire logic [WIDTH-1:0] wr_data_in,
  input wire logic [AW-1:0] rd_addr_in,
  output logic [WIDTH-1:0] rd_data_out
);
  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [WIDTH-1:0] rd_data_next;

  always_comb begin
    rd_data_next = mem_reg[rd_addr_in];
  end

  // Array itself has no reset so it maps onto block memory
  always_ff @(posedge sys_clk_in) begin
    if (wr_en_in) begin
      mem_reg[wr_addr_in] <= wr_data_in;
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (!rstn_in) begin
      rd_data_out <= '0;
    end else begin
      rd_data_out <= rd_data_next;
    end
  end
endmodule // fps_buf_mem

/* File: tb/fps_ctrl_chk.sv */
`timescale 1ns/100ps
module fps_ctrl_chk (
  input wire logic sys_clk_in,
  input wire logic rstn_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  input wire logic [31:0] reg_rdata_out,
  input wire logic irq_out,
  input wire fps_pkg::fps_bus_t flash_bus_out
);
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (!rstn_in);
  wire we_n = flash_bus_out.we_n;
  wire ce_n = flash_bus_out.ce_n;
  wire [15:0] dq = flash_bus_out.dq;
  wire opens_seq = dq == 16'h0060 || dq == 16'h00C0 || dq == 16'h00B8 ||
                   dq == 16'h00EB;
  sequence strobe_low;
    !we_n [*3] ##1 we_n;
  endsequence
  sequence hold_tail;
    (!ce_n && $stable(dq)) [*2] ##1 ce_n;
  endsequence
  we_strobe_a: assert property ($fell(we_n) |-> strobe_low)
    else $error("write strobe not three cycles low");
  we_hold_a: assert property ($rose(we_n) |-> hold_tail)
    else $error("write hold phase broken");
  we_setup_a: assert property ($fell(we_n) |->
    $past(!ce_n) && $past(flash_bus_out.dq_oe))
    else $error("no setup cycle before strobe");
  drive_oe_a: assert property (!ce_n |-> flash_bus_out.dq_oe)
    else $error("chip selected without driving data");
  word_stable_a: assert property (!ce_n && $past(!ce_n) |->
    $stable(flash_bus_out.addr) && $stable(dq))
    else $error("address or data moved inside a write");
  seq_second_a: assert property ($rose(we_n) && opens_seq |->
    ##[2:12] $fell(we_n))
    else $error("setup code not followed by a second write");
  idle_gap_a: assert property ($rose(ce_n) |-> we_n && !flash_bus_out.dq_oe)
    else $error("bus not released between writes");
  read_off_a: assert property (flash_bus_out.oe_n)
    else $error("output enable driven low");
  rd_zero_a: assert property (!$past(reg_rd_in) |-> reg_rdata_out == 32'h0)
    else $error("read data outside read slot");
  irq_cause_a: assert property ($fell(irq_out) |->
    $past(reg_wr_in) || $past(reg_wr_in, 2))
    else $error("interrupt dropped without a write");
endmodule // fps_ctrl_chk

/* File: tb/fps_flash_model.sv */
`timescale 1ns/100ps
module fps_flash_model #(
  parameter int BUSY_NS = 400,
  parameter int PULSE_NS = 250
) (
  input wire fps_pkg::fps_bus_t bus_in,
  input wire logic erase_done_in,
  output logic [15:0] dq_out,
  output logic sts_out
);
  logic [255:0] lock_bits = '0;
  logic [1:0] fail_flags = 2'h0;
  logic [1:0] sts_mode = 2'h0;
  logic [23:0] otp_addr, ef_last;
  logic [15:0] otp_word, last_dq = 16'h0;
  logic [15:0] ef_sum = 16'h0;
  logic [7:0] code;
  logic busy = 1'b0;
  logic pulse = 1'b0;
  int st = 0;
  int ef_left, ef_words;
  // Released DQ shows the inverse so a stale value never passes
  assign dq_out = bus_in.dq_oe ? bus_in.dq : ~last_dq;
  // Pulse modes hide busy; pin idles high
  assign sts_out = (sts_mode == 2'h0) ? !busy : !pulse;
  task automatic finish(input bit is_erase);
    fork begin
      busy = 1'b1;
      #(BUSY_NS);
      busy = 1'b0;
      if (is_erase ? sts_mode[0] : sts_mode[1]) begin
        pulse = 1'b1;
        #(PULSE_NS);
        pulse = 1'b0;
      end
    end join_none
  endtask
  always @(posedge erase_done_in) finish(1'b1);
  always @(posedge bus_in.we_n) begin
    if (bus_in.ce_n === 1'b0) begin
      last_dq = bus_in.dq;
      code = bus_in.dq[7:0];
      case (st)
        1: begin
          if (code == 8'h01) lock_bits[bus_in.addr[23:16]] = 1'b1;
          else if (code == 8'hD0) lock_bits = '0;
          else fail_flags = 2'h3;
          st = 0;
        end
        2: begin
          otp_addr = bus_in.addr;
          otp_word = bus_in.dq;
          finish(1'b0);
          st = 0;
        end
        3: begin
          sts_mode = code[1:0];
          st = 0;
        end
        4: st = 5;
        5: begin
          ef_left = int'(bus_in.dq[8:0]) + 1;
          ef_words = 0;
          ef_sum = 16'h0;
          st = 6;
        end
        6: begin
          ef_words++;
          ef_last = bus_in.addr;
          ef_sum = ef_sum + (bus_in.dq ^ bus_in.addr[15:0]);
          if (ef_words == ef_left) st = 7;
        end
        7: begin
          if (code == 8'hD0) finish(1'b0);
          else fail_flags = 2'h3;
          st = 0;
        end
        default: begin
          if (code == 8'h60) st = 1;
          else if (code == 8'hC0) st = 2;
          else if (code == 8'hB8) st = 3;
          else if (code == 8'hEB) st = 4;
          else if (code == 8'h50) fail_flags = 2'h0;
        end
      endcase
    end
  end
endmodule // fps_flash_model

/* File: tb/fps_ctrl_test.sv */
`timescale 1ns/100ps
module fps_ctrl_test;
  logic sys_clk_in = 1'b0;
  logic rstn_in = 1'b0;
  logic [7:0] reg_addr_in = 8'h00;
  logic [31:0] reg_wdata_in = 32'h0;
  logic reg_wr_in = 1'b0;
  logic reg_rd_in = 1'b0;
  logic [31:0] reg_rdata_out, rv;
  logic irq_out, flash_sts_in;
  logic erase_done = 1'b0;
  fps_pkg::fps_bus_t flash_bus_out;
  logic [15:0] flash_dq_in;
  int n_errors = 0;
  int n_checks = 0;
  int n_pulses = 0;
  int cycles = 0;
  always #12.5 sys_clk_in = ~sys_clk_in;
  fps_ctrl dut (.sys_clk_in(sys_clk_in), .rstn_in(rstn_in),
    .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in),
    .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
    .reg_rdata_out(reg_rdata_out), .irq_out(irq_out),
    .flash_bus_out(flash_bus_out), .flash_dq_in(flash_dq_in),
    .flash_sts_in(flash_sts_in));
  fps_flash_model u_model (.bus_in(flash_bus_out),
    .erase_done_in(erase_done), .dq_out(flash_dq_in),
    .sts_out(flash_sts_in));
  always @(negedge flash_sts_in) n_pulses++;
  always @(posedge sys_clk_in) begin
    cycles++;
    if (cycles == 20000) begin
      n_errors++;
      conclude();
    end
  end
  task automatic conclude();
    $display("checks %0d mismatches %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk_in);
    reg_addr_in <= a;
    reg_wdata_in <= d;
    reg_wr_in <= 1'b1;
    @(posedge sys_clk_in);
    reg_wr_in <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge sys_clk_in);
    reg_addr_in <= a;
    reg_rd_in <= 1'b1;
    @(posedge sys_clk_in);
    reg_rd_in <= 1'b0;
    #1 d = reg_rdata_out;
  endtask
  // Waits on the done interrupt, then clears it
  task automatic run_op(input logic [2:0] op, input logic [23:0] a,
                        input logic [15:0] d, input logic [8:0] n);
    wr(fps_pkg::REG_ADDR, {8'h00, a});
    wr(fps_pkg::REG_DATA, {16'h0000, d});
    wr(fps_pkg::REG_COUNT, {23'h0, n});
    wr(fps_pkg::REG_CTRL, {23'h0, 1'b1, 5'h00, op});
    repeat (400) begin
      if (irq_out !== 1'b1) begin
        @(posedge sys_clk_in);
        #1;
      end
    end
    chk("irq_done", 32'h1, {31'h0, irq_out});
    wr(fps_pkg::REG_IRQ_STAT, 32'h0000_0001);
    repeat (2) @(posedge sys_clk_in);
    #1 chk("irq_clear", 32'h0, {31'h0, irq_out});
  endtask
  task automatic t_reset();
    chk("bus_idle", 32'h1, {31'h0, flash_bus_out === fps_pkg::BUS_IDLE});
    rd(8'h40, rv);
    chk("unmapped", 32'h0, rv);
    rd(fps_pkg::REG_BUF_DATA, rv);
    chk("dq_idle", 32'h0000_FFFF, rv);
    rd(fps_pkg::REG_STATUS, rv);
    chk("mode_reset", 32'h0, {30'h0, rv[2:1]});
    chk("pin_ready", 32'h1, {31'h0, rv[3]});
    wr(fps_pkg::REG_IRQ_MASK, 32'h0000_0001);
    $display("test reset done");
  endtask
  task automatic t_lock();
    run_op(fps_pkg::OP_LOCK, 24'h03_0000, 16'h0000, 9'h000);
    run_op(fps_pkg::OP_LOCK, 24'h05_1234, 16'h0000, 9'h000);
    chk("lock_b3", 32'h1, {31'h0, u_model.lock_bits[3]});
    chk("lock_b4", 32'h0, {31'h0, u_model.lock_bits[4]});
    chk("lock_b5", 32'h1, {31'h0, u_model.lock_bits[5]});
    run_op(fps_pkg::OP_UNLOCK_ALL, 24'h03_0000, 16'h0000, 9'h000);
    chk("unlock_all", 32'h0, {31'h0, |u_model.lock_bits});
    run_op(fps_pkg::OP_LOCK_RAW, 24'h00_0000, 16'h0077, 9'h000);
    chk("seq_err", 32'h3, {30'h0, u_model.fail_flags});
    run_op(fps_pkg::OP_LOCK, 24'h01_0000, 16'h0000, 9'h000);
    chk("err_kept", 32'h3, {30'h0, u_model.fail_flags});
    run_op(fps_pkg::OP_CLEAR_STATUS, 24'h0, 16'h0000, 9'h000);
    chk("err_clear", 32'h0, {30'h0, u_model.fail_flags});
    $display("test lock done");
  endtask
  task automatic t_ext();
    wr(fps_pkg::REG_BUF_PTR, 32'h0);
    for (int i = 1; i < 4; i++) wr(fps_pkg::REG_BUF_DATA, 32'(i * 4369));
    run_op(fps_pkg::OP_EXT_FUNC, 24'h00_1000, 16'h0005, 9'h002);
    chk("ef_words", 32'h3, 32'(u_model.ef_words));
    chk("ef_last", 32'h1002, {8'h0, u_model.ef_last});
    chk("ef_data", 32'h5665, {16'h0, u_model.ef_sum});
    chk("ef_confirm", 32'h0, 32'(u_model.st));
    chk("ef_err", 32'h0, {30'h0, u_model.fail_flags});
    $display("test extended done");
  endtask
  task automatic t_sts();
    logic [1:0] c;
    for (int i = 0; i < 4; i++) begin
      c = 2'(i);
      run_op(fps_pkg::OP_STS_CONFIG, 24'h0, {14'h0, c}, 9'h000);
      rd(fps_pkg::REG_STATUS, rv);
      chk("mode_field", {30'h0, c}, {30'h0, rv[2:1]});
      chk("dev_mode", {30'h0, c}, {30'h0, u_model.sts_mode});
      wr(fps_pkg::REG_IRQ_STAT, 32'h0000_0002);
      n_pulses = 0;
      run_op(fps_pkg::OP_PROT_PROG, 24'h80, {14'h2973, c}, 9'h0);
      chk("otp_word", {16'h0, 14'h2973, c}, {16'h0, u_model.otp_word});
      chk("otp_addr", 32'h80, {8'h0, u_model.otp_addr});
      repeat (40) @(posedge sys_clk_in);
      erase_done <= 1'b1;
      @(posedge sys_clk_in);
      erase_done <= 1'b0;
      repeat (40) @(posedge sys_clk_in);
      chk("pulses", (c == 2'h0) ? 32'h2 : {31'h0, c[0]} + {31'h0, c[1]},
          32'(n_pulses));
      rd(fps_pkg::REG_IRQ_STAT, rv);
      chk("pin_event", 32'h2, rv & 32'h2);
      chk("irq_masked", 32'h0, {31'h0, irq_out});
    end
    $display("test completion pin done");
  endtask
  initial begin
    repeat (10) @(posedge sys_clk_in);
    rstn_in <= 1'b1;
    repeat (4) @(posedge sys_clk_in);
    t_reset();
    t_lock();
    t_ext();
    t_sts();
    conclude();
  end
endmodule // fps_ctrl_test
bind fps_ctrl fps_ctrl_chk u_chk (.sys_clk_in(sys_clk_in),
  .rstn_in(rstn_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
  .reg_rdata_out(reg_rdata_out), .irq_out(irq_out),
  .flash_bus_out(flash_bus_out));
